/* File: iam_pkg.sv */
// Constants and carrier types for the integer add / float mul-div unit
package iam_pkg;

  localparam logic [5:0] OPC_INT_SUM   = 6'h1e;
  localparam logic [5:0] OPC_INT_DIFF  = 6'h1f;
  localparam logic [5:0] OPC_FMUL      = 6'h20;
  localparam logic [5:0] OPC_FMUL_DBL  = 6'h22;
  localparam logic [5:0] OPC_FDIV      = 6'h24;
  localparam logic [5:0] OPC_FDIV_RND  = 6'h25;

  localparam logic [10:0] EXP_FLD_INF   = 11'h7ff;
  localparam logic [10:0] EXP_FLD_INDEF = 11'h3ff;
  localparam logic [10:0] EXP_FLD_POS   = 11'h400;
  localparam logic signed [13:0] EXP_POS_BIAS = 14'sh400;
  localparam logic signed [13:0] EXP_NEG_BIAS = 14'sh3ff;
  localparam logic signed [13:0] EXP_MAX      = 14'sh3ff;
  localparam logic signed [13:0] EXP_MIN      = -14'sh3ff;
  localparam logic signed [13:0] EXP_HALF     = 14'sh30;
  localparam logic signed [13:0] EXP_HALF_M1  = 14'sh2f;
  localparam logic signed [13:0] EXP_ONE      = 14'sh1;

  localparam logic [95:0] MUL_ROUND_BIT = 96'h4000_0000_0000;
  localparam logic [47:0] DIV_RND_48    = 48'h5555_5555_5555;
  localparam logic [47:0] DIV_RND_47    = 48'h2aaa_aaaa_aaaa;
  localparam logic [5:0]  DIV_LAST_STEP = 6'h2f;

  localparam logic [59:0] WORD_INF   = {1'b0, EXP_FLD_INF, 48'h0};
  localparam logic [59:0] WORD_INDEF = {1'b0, EXP_FLD_INDEF, 48'h0};

  typedef struct packed {
    logic [5:0]  opcode;
    logic [2:0]  dest_sel;
    logic [2:0]  src1_sel;
    logic [2:0]  src2_sel;
    logic [59:0] first_operand_reg;
    logic [59:0] second_operand_reg;
  } iam_issue_t;

  typedef struct packed {
    logic [2:0]  dest_sel;
    logic [59:0] result_operand_reg;
    logic        exit_infinite;
    logic        exit_indefinite;
    logic        divide_fault;
  } iam_result_t;

  typedef struct packed {
    logic               sign;
    logic signed [13:0] exp;
    logic [47:0]        coef;
    logic               inf;
    logic               indef;
    logic               norm;
    logic               int_form;
  } iam_unp_t;

endpackage : iam_pkg

/* File: iam_unit.sv */
// Integer sum/difference, float multiply and float divide datapath
`timescale 1ns/1ps

module iam_unit
  import iam_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        ISSUE_VALID_I,
  input  wire iam_issue_t  ISSUE_I,
  output logic             ISSUE_READY_O,
  output logic             BUSY_O,
  output logic             RESULT_VALID_O,
  output iam_result_t      RESULT_O
);

  typedef enum logic {ST_IDLE, ST_DIV} iam_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Format helpers

  // Negative words are the ones' complement of the positive word
  function automatic iam_unp_t unpack(input logic [59:0] w);
    logic [59:0] p;
    iam_unp_t    u;
    p          = w[59] ? ~w : w;
    u.sign     = w[59];
    u.exp      = p[58] ? 14'($signed({3'h0, p[58:48]}) - EXP_POS_BIAS)
                       : 14'($signed({3'h0, p[58:48]}) - EXP_NEG_BIAS);
    u.coef     = p[47:0];
    u.inf      = (p[58:48] == EXP_FLD_INF);
    u.indef    = (p[58:48] == EXP_FLD_INDEF);
    u.norm     = p[47];
    u.int_form = (w[59:48] == 12'h000) || (w[59:48] == 12'hfff);
    return u;
  endfunction : unpack

  // Out-of-range exponent gives infinite or zero, never a wrapped field
  function automatic logic [59:0] pack(input logic               s,
                                       input logic signed [13:0] e,
                                       input logic [47:0]        c);
    logic [10:0] f;
    logic [59:0] w;
    f = (e >= 0) ? 11'(e + EXP_POS_BIAS) : 11'(e + EXP_NEG_BIAS);
    if (e > EXP_MAX) begin
      w = WORD_INF;
    end else if (e < EXP_MIN) begin
      w = 60'h0;
    end else begin
      w = {1'b0, f, c};
    end
    return s ? ~w : w;
  endfunction : pack

  function automatic logic out_of_range(input logic signed [13:0] e);
    return (e > EXP_MAX) || (e < EXP_MIN);
  endfunction : out_of_range

  ////////////////////////////////////////////////////////////////////////////
  // Issue decode

  iam_state_t  state_r;
  iam_state_t  state_nxt;
  wire logic   accept;
  wire logic   op_isum;
  wire logic   op_idiff;
  wire logic   op_fmul;
  wire logic   op_fmul_dbl;
  wire logic   op_fdiv;
  wire logic   op_fdiv_rnd;
  wire logic   op_div_any;
  wire logic   op_fast;

  assign ISSUE_READY_O = (state_r == ST_IDLE);
  assign BUSY_O        = (state_r == ST_DIV);
  assign accept        = ISSUE_VALID_I && ISSUE_READY_O;
  assign op_isum       = (ISSUE_I.opcode == OPC_INT_SUM);
  assign op_idiff      = (ISSUE_I.opcode == OPC_INT_DIFF);
  assign op_fmul       = (ISSUE_I.opcode == OPC_FMUL);
  assign op_fmul_dbl   = (ISSUE_I.opcode == OPC_FMUL_DBL);
  assign op_fdiv       = (ISSUE_I.opcode == OPC_FDIV);
  assign op_fdiv_rnd   = (ISSUE_I.opcode == OPC_FDIV_RND);
  assign op_div_any    = op_fdiv || op_fdiv_rnd;
  assign op_fast       = op_isum || op_idiff || op_fmul || op_fmul_dbl;

  wire iam_unp_t uj;
  wire iam_unp_t uk;

  assign uj = unpack(ISSUE_I.first_operand_reg);
  assign uk = unpack(ISSUE_I.second_operand_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Integer sum and difference, ones' complement with end-around carry

  wire logic [59:0] int_addend;
  wire logic [60:0] int_raw;
  wire logic [59:0] int_res;

  assign int_addend = op_idiff ? ~ISSUE_I.second_operand_reg
                               : ISSUE_I.second_operand_reg;
  assign int_raw    = {1'b0, ISSUE_I.first_operand_reg} + {1'b0, int_addend};
  // No overflow flag: the carry only wraps around
  assign int_res    = int_raw[59:0] + {59'h0, int_raw[60]};

  ////////////////////////////////////////////////////////////////////////////
  // Multiply

  wire logic               mul_sign;
  wire logic               mul_norm;
  wire logic               mul_int;
  wire logic               mul_inf;
  wire logic               mul_indef;
  wire logic [95:0]        prod;
  wire logic [95:0]        prod_rnd;
  wire logic signed [13:0] exp_sum;
  wire logic               sgl_shift;
  wire logic               dbl_shift;
  wire logic [47:0]        sgl_coef;
  wire logic [47:0]        dbl_coef;
  wire logic signed [13:0] sgl_exp;
  wire logic signed [13:0] dbl_exp;
  wire logic [59:0]        int_prod;
  wire logic [59:0]        mul_res;

  assign mul_sign  = uj.sign ^ uk.sign;
  assign mul_norm  = uj.norm && uk.norm;
  assign mul_inf   = uj.inf || uk.inf;
  assign mul_indef = uj.indef || uk.indef;
  assign mul_int   = uj.int_form && uk.int_form && !uj.norm && !uk.norm;
  assign prod      = {48'h0, uj.coef} * {48'h0, uk.coef};
  assign exp_sum   = 14'(uj.exp + uk.exp);
  assign prod_rnd  = prod + MUL_ROUND_BIT;

  // Leading-bit search only when both inputs are normalized
  assign sgl_shift = mul_norm && !prod_rnd[95];
  assign sgl_coef  = sgl_shift ? prod_rnd[94:47] : prod_rnd[95:48];
  assign sgl_exp   = sgl_shift ? 14'(exp_sum + EXP_HALF_M1)
                               : 14'(exp_sum + EXP_HALF);

  assign dbl_shift = mul_norm && !prod[95];
  assign dbl_coef  = dbl_shift ? {prod[46:0], 1'b0} : prod[47:0];
  assign dbl_exp   = dbl_shift ? 14'(exp_sum - EXP_ONE) : exp_sum;

  // Bits above 48 are lost silently in integer form
  assign int_prod  = mul_sign ? ~{12'h0, prod[47:0]}
                              : {12'h0, prod[47:0]};

  assign mul_res   = mul_indef ? WORD_INDEF :
                     mul_inf   ? WORD_INF :
                     op_fmul   ? pack(mul_sign, sgl_exp, sgl_coef) :
                     mul_int   ? int_prod :
                                 pack(mul_sign, dbl_exp, dbl_coef);

  ////////////////////////////////////////////////////////////////////////////
  // Divide setup

  wire logic               div_small;
  wire logic [47:0]        div_hi;
  wire logic [47:0]        div_lo;
  wire logic [47:0]        div_pat;
  wire logic signed [13:0] div_exp;
  wire logic               div_fault;

  // Extra quotient bit when dividend coefficient is below divisor
  assign div_small = (uj.coef < uk.coef);
  assign div_hi    = div_small ? uj.coef : {1'b0, uj.coef[47:1]};
  assign div_pat   = !op_fdiv_rnd ? 48'h0 :
                     div_small    ? DIV_RND_48 : DIV_RND_47;
  assign div_lo    = (div_small ? 48'h0 : {uj.coef[0], 47'h0}) | div_pat;
  assign div_exp   = div_small ? 14'(uj.exp - uk.exp - EXP_HALF)
                               : 14'(uj.exp - uk.exp - EXP_HALF_M1);
  assign div_fault = ({1'b0, uj.coef} >= {uk.coef, 1'b0});

  ////////////////////////////////////////////////////////////////////////////
  // Divide iteration, one quotient bit per clock

  logic [47:0]        rem_r;
  logic [47:0]        low_r;
  logic [47:0]        quo_r;
  logic [47:0]        dvs_r;
  logic [5:0]         cnt_r;
  logic signed [13:0] dexp_r;
  logic               dsign_r;
  logic               dfault_r;
  logic               dinf_r;
  logic               dindef_r;
  logic [2:0]         ddest_r;

  wire logic [48:0] trial;
  wire logic        trial_ge;
  wire logic [47:0] rem_nxt;
  wire logic [47:0] quo_nxt;
  wire logic        div_done;

  assign trial    = {rem_r, low_r[47]};
  assign trial_ge = (trial >= {1'b0, dvs_r});
  assign rem_nxt  = trial_ge ? 48'(trial - {1'b0, dvs_r}) : trial[47:0];
  assign quo_nxt  = {quo_r[46:0], trial_ge};
  assign div_done = (state_r == ST_DIV) && (cnt_r == DIV_LAST_STEP);

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rem_r <= 48'h0;
      low_r <= 48'h0;
      quo_r <= 48'h0;
      cnt_r <= 6'h0;
    end else if (accept && op_div_any) begin
      rem_r <= div_hi;
      low_r <= div_lo;
      quo_r <= 48'h0;
      cnt_r <= 6'h0;
    end else if (state_r == ST_DIV) begin
      rem_r <= rem_nxt;
      low_r <= {low_r[46:0], 1'b0};
      quo_r <= quo_nxt;
      cnt_r <= 6'(cnt_r + 6'h1);
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      dvs_r    <= 48'h0;
      dexp_r   <= 14'sh0;
      dsign_r  <= 1'b0;
      dfault_r <= 1'b0;
      dinf_r   <= 1'b0;
      dindef_r <= 1'b0;
      ddest_r  <= 3'h0;
    end else if (accept && op_div_any) begin
      dvs_r    <= uk.coef;
      dexp_r   <= div_exp;
      dsign_r  <= mul_sign;
      dfault_r <= div_fault;
      dinf_r   <= mul_inf;
      dindef_r <= mul_indef;
      ddest_r  <= ISSUE_I.dest_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result selection and write-back

  wire logic [59:0] div_word;
  iam_result_t      fast_rsp;
  iam_result_t      div_rsp;
  iam_result_t      rsp_nxt;
  iam_result_t      rsp_r;
  logic             rsp_valid_r;
  wire logic        rsp_load;

  // Range failure wins over the fault so the caller sees it
  assign div_word = dindef_r               ? WORD_INDEF :
                    dinf_r                 ? WORD_INF :
                    out_of_range(dexp_r)   ? pack(dsign_r, dexp_r, quo_nxt) :
                    dfault_r               ? WORD_INDEF :
                    pack(dsign_r, dexp_r, quo_nxt);

  always_comb begin
    fast_rsp.dest_sel           = ISSUE_I.dest_sel;
    fast_rsp.result_operand_reg = (op_isum || op_idiff) ? int_res : mul_res;
    fast_rsp.exit_infinite      = (op_fmul || op_fmul_dbl) && mul_inf;
    fast_rsp.exit_indefinite    = (op_fmul || op_fmul_dbl) && mul_indef;
    fast_rsp.divide_fault       = 1'b0;
    div_rsp.dest_sel            = ddest_r;
    div_rsp.result_operand_reg  = div_word;
    div_rsp.exit_infinite       = dinf_r;
    div_rsp.exit_indefinite     = dindef_r;
    div_rsp.divide_fault        = dfault_r && !dinf_r && !dindef_r;
    rsp_nxt                     = div_done ? div_rsp : fast_rsp;
  end

  assign rsp_load = div_done || (accept && op_fast);

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rsp_r       <= '0;
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_valid_r <= rsp_load;
      if (rsp_load) begin
        rsp_r <= rsp_nxt;
      end
    end
  end

  assign RESULT_VALID_O = rsp_valid_r;
  assign RESULT_O       = rsp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (accept && op_div_any) begin
          state_nxt = ST_DIV;
        end
      end
      ST_DIV: begin
        if (div_done) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

endmodule : iam_unit

/* File: iam_issue_model.sv */
// Issue-side model: presents requests and holds them until taken
`timescale 1ns/1ps

module iam_issue_model
  import iam_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  ready_i,
  output logic       valid_o,
  output iam_issue_t issue_o
);

  initial begin
    valid_o = 1'b0;
    issue_o = '0;
  end

  // Entered just after an edge; returns just after the edge that took it
  task automatic send(input iam_issue_t req);
    logic taken;
    valid_o = 1'b1;
    issue_o = req;
    do begin
      @(negedge clk_i);
      taken = ready_i;
      @(posedge clk_i);
    end while (taken !== 1'b1);
    #1;
  endtask : send

  // Released lines must not keep showing the last request
  task automatic idle();
    valid_o = 1'b0;
    issue_o = ~issue_o;
  endtask : idle

endmodule : iam_issue_model

/* File: iam_unit_properties.sv */
// Concurrent checks on the unit's issue and result ports
`timescale 1ns/1ps

module iam_unit_properties
  import iam_pkg::*;
(
  input wire logic        REF_CLK_I,
  input wire logic        RESET_I,
  input wire logic        ISSUE_VALID_I,
  input wire iam_issue_t  ISSUE_I,
  input wire logic        ISSUE_READY_O,
  input wire logic        BUSY_O,
  input wire logic        RESULT_VALID_O,
  input wire iam_result_t RESULT_O
);

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  wire logic acc      = ISSUE_VALID_I && ISSUE_READY_O;
  wire logic op_div   = ISSUE_I.opcode inside {OPC_FDIV, OPC_FDIV_RND};
  wire logic op_int   = ISSUE_I.opcode inside {OPC_INT_SUM, OPC_INT_DIFF};
  wire logic op_mul   = ISSUE_I.opcode inside {OPC_FMUL, OPC_FMUL_DBL};
  wire logic acc_div  = acc && op_div;
  wire logic acc_fast = acc && (op_int || op_mul);
  wire logic [2:0] flags = {RESULT_O.exit_infinite,
                            RESULT_O.exit_indefinite, RESULT_O.divide_fault};

  chk_fast_answer: assert property (acc_fast |=> RESULT_VALID_O)
    else $error("fast operation gave no result next cycle");
  chk_int_flags: assert property (acc && op_int |=> flags == 3'h0)
    else $error("integer operation raised a flag");
  chk_dest_echo: assert property (acc_fast |=>
    RESULT_O.dest_sel == $past(ISSUE_I.dest_sel))
    else $error("result destination differs from request");
  chk_div_busy: assert property (acc_div |=> BUSY_O [*8])
    else $error("busy not raised after divide accept");
  chk_div_answer: assert property (acc_div |-> ##48 BUSY_O
    ##1 (RESULT_VALID_O && !BUSY_O))
    else $error("divide result not at cycle 49");
  chk_busy_refuse: assert property (BUSY_O |-> !ISSUE_READY_O)
    else $error("ready while busy");
  chk_busy_quiet: assert property (BUSY_O |-> !RESULT_VALID_O)
    else $error("result while divide still running");
  chk_mul_infinite: assert property (acc && op_mul &&
    ISSUE_I.first_operand_reg == WORD_INF |=> RESULT_O.exit_infinite)
    else $error("infinite multiply operand raised no exit");
  chk_div_indef: assert property (acc_div &&
    ISSUE_I.second_operand_reg == WORD_INDEF
    |-> ##49 RESULT_O.exit_indefinite)
    else $error("indefinite divisor raised no exit");

  cov_divide: cover property (acc_div);
  cov_back_to_back: cover property (acc_fast ##1 acc_fast);
  cov_held: cover property (BUSY_O && ISSUE_VALID_I);

endmodule : iam_unit_properties

bind iam_unit iam_unit_properties i_chk (
  .REF_CLK_I     (REF_CLK_I),
  .RESET_I       (RESET_I),
  .ISSUE_VALID_I (ISSUE_VALID_I),
  .ISSUE_I       (ISSUE_I),
  .ISSUE_READY_O (ISSUE_READY_O),
  .BUSY_O        (BUSY_O),
  .RESULT_VALID_O(RESULT_VALID_O),
  .RESULT_O      (RESULT_O)
);

/* File: iam_unit_tb.sv */
// Self-checking bench for the integer add / float mul-div unit
`timescale 1ns/1ps

module iam_unit_tb;
  import iam_pkg::*;

  localparam logic [47:0] NRM = 48'h8000_0000_0000;
  localparam logic [10:0] E0  = 11'h400;

  logic        ref_clk;
  logic        reset;
  logic        valid;
  iam_issue_t  issue;
  logic        ready;
  logic        busy;
  logic        res_valid;
  iam_result_t result;
  iam_result_t res_q[$];
  int          err_total;
  int          samples_checked;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  iam_unit i_dut (
    .REF_CLK_I     (ref_clk),
    .RESET_I       (reset),
    .ISSUE_VALID_I (valid),
    .ISSUE_I       (issue),
    .ISSUE_READY_O (ready),
    .BUSY_O        (busy),
    .RESULT_VALID_O(res_valid),
    .RESULT_O      (result)
  );

  iam_issue_model i_iss (
    .clk_i  (ref_clk),
    .ready_i(ready),
    .valid_o(valid),
    .issue_o(issue)
  );

  always @(posedge ref_clk) if (res_valid === 1'b1) res_q.push_back(result);

  function automatic logic [59:0] fw(input logic [10:0] f,
                                     input logic [47:0] c);
    return {1'b0, f, c};
  endfunction : fw

  function automatic iam_issue_t rq(input logic [5:0] op,
                                    input logic [59:0] j, k);
    return '{op, 3'h5, 3'h1, 3'h2, j, k};
  endfunction : rq

  task automatic check(input string what, input logic [59:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // Bounded wait so a lost result shows as a mismatch, not a hang
  task automatic pop_res(output iam_result_t r);
    int n;
    n = 0;
    while (res_q.size() == 0 && n < 60) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    r = (res_q.size() != 0) ? res_q.pop_front() : 'x;
  endtask : pop_res

  task automatic t_int_ops();
    iam_result_t r;
    check("ready after reset", ready, 1'b1);
    check("busy after reset", busy, 1'b0);
    i_iss.send(rq(OPC_INT_SUM, 60'h5, 60'h3));
    i_iss.send(rq(OPC_INT_DIFF, 60'h3, 60'h5));
    i_iss.idle();
    pop_res(r);
    check("sum", r.result_operand_reg, 60'h8);
    check("destination", r.dest_sel, 3'h5);
    pop_res(r);
    check("difference", r.result_operand_reg, ~60'h2);
    $display("t_int_ops done");
  endtask : t_int_ops

  task automatic t_fmul();
    iam_result_t r;
    i_iss.send(rq(OPC_FMUL, fw(E0, NRM + 1), fw(E0, NRM + 1)));
    i_iss.send(rq(OPC_FMUL, fw(E0, 48'h100_0000_0000),
                  fw(E0, 48'h100_0000_0000)));
    i_iss.send(rq(OPC_FMUL_DBL, fw(E0, NRM + 1), fw(E0, NRM + 1)));
    i_iss.send(rq(OPC_FMUL_DBL, 60'h6, ~60'h7));
    i_iss.idle();
    pop_res(r);
    check("single norm", r.result_operand_reg,
          fw(11'h42f, NRM + 2));
    pop_res(r);
    check("single unnorm", r.result_operand_reg,
          fw(11'h430, 48'h1_0000_0000));
    pop_res(r);
    check("double norm", r.result_operand_reg,
          fw(11'h3fe, 48'h2));
    pop_res(r);
    check("integer product", r.result_operand_reg, ~60'd42);
    $display("t_fmul done");
  endtask : t_fmul

  task automatic t_divide();
    iam_result_t r;
    i_iss.send(rq(OPC_FDIV, fw(E0, NRM), fw(E0, 48'hc000_0000_0000)));
    // Held behind the divide; must not be lost
    i_iss.send(rq(OPC_INT_SUM, 60'h1, 60'h1));
    i_iss.send(rq(OPC_FDIV_RND, fw(E0, NRM), fw(E0, 48'hc000_0000_0000)));
    i_iss.send(rq(OPC_FDIV, fw(E0, NRM), fw(E0, 48'h4000_0000_0000)));
    i_iss.send(rq(OPC_FDIV, fw(11'h7e8, NRM),
                  fw(11'h017, 48'h4000_0000_0000)));
    i_iss.idle();
    pop_res(r);
    check("quotient", r.result_operand_reg,
          fw(11'h3cf, 48'haaaa_aaaa_aaaa));
    pop_res(r);
    check("held sum", r.result_operand_reg, 60'h2);
    pop_res(r);
    check("rounded quotient", r.result_operand_reg,
          fw(11'h3cf, 48'haaaa_aaaa_aaab));
    pop_res(r);
    check("fault word", r.result_operand_reg, WORD_INDEF);
    check("fault flag", r.divide_fault, 1'b1);
    pop_res(r);
    check("overflow word", r.result_operand_reg, WORD_INF);
    $display("t_divide done");
  endtask : t_divide

  task automatic t_exits();
    iam_result_t r;
    i_iss.send(rq(OPC_FMUL, WORD_INF, fw(E0, NRM)));
    i_iss.send(rq(OPC_FDIV, fw(E0, NRM), WORD_INDEF));
    i_iss.idle();
    pop_res(r);
    check("infinite exit", r.exit_infinite, 1'b1);
    pop_res(r);
    check("indefinite exit", r.exit_indefinite, 1'b1);
    $display("t_exits done");
  endtask : t_exits

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #(2000 * 100);
    err_total++;
    tally_and_finish();
  end

  initial begin
    err_total = 0;
    samples_checked = 0;
    reset = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    t_int_ops();
    t_fmul();
    t_divide();
    t_exits();
    tally_and_finish();
  end

endmodule : iam_unit_tb
